// ### core/rsw_ctrl.v
/*
 Reset-source and watchdog controller, APB slave, single pclk domain.
 Assumes the core gives one-cycle pulses for the watchdog clear and
 halt instructions on pclk, and that the low-speed oscillator clock,
 low-supply flag and sleep level come from outside and are synchronised.
*/
// Contract
// - Key 10101 disables, 01010 enables watchdog
// - Other watchdog key resets after delay
// - Watchdog key powers up enabled
// - Overflow while running: reset, set expired
// - Overflow asleep: expired, clear PC/SP only
// - Clear counter: bad key, clear, halt
// - Timeouts span 2^8 to 2^18 ticks
// - Reset key 55/AA idle, else reset
// - Reset key powers up to 55
// - Bad reset key sets cause bit 3
// - Resets restore key except watchdog warm
// - Soft-key flag hardware set, software clear
// - Brownout only after qualify time
// - Brownout key 5A enables, A5 disables
// - Bad brownout key resets, bit 1, restore
// - Real brownout keeps brownout key
// - Brownout key powers up to 5A
// - Brownout disabled in sleep or idle; code gates it only on sleep_mode
// - Brownout sets bit 2, software clears
// - Flash control 55 resets whole device
// - Power-on: PC zero, ports as inputs
// - Select code picks divide ratio
// - Bad watchdog key sets bit 0
`timescale 1ns/1ps
`include "rsw_consts.vh"

module rsw_ctrl
#(
   parameter KEY_DELAY_CYC = `RSW_KEY_DELAY_CYC,
   parameter BOR_QUAL_CYC  = `RSW_BOR_QUAL_CYC
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        low_speed_internal_osc_clk,
   input  wire        low_supply,
   input  wire        sleep_mode,
   input  wire        watchdog_clear_instruction,
   input  wire        halt_instruction,
   output reg         sys_reset,
   output reg         pc_sp_clear,
   output reg         watchdog_expired_flag,
   output reg         port_init
);

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   reg [2:0] low_speed_internal_osc_s_r;
   reg [1:0] low_s_r;
   reg [1:0] slp_s_r;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_speed_internal_osc_s_r <= 3'h0;
         low_s_r  <= 2'h0;
         slp_s_r  <= 2'h0;
      end
      else
      begin
         low_speed_internal_osc_s_r <= {low_speed_internal_osc_s_r[1:0], low_speed_internal_osc_clk};
         low_s_r  <= {low_s_r[0], low_supply};
         slp_s_r  <= {slp_s_r[0], sleep_mode};
      end
   end
   // Edge taken between second and third stage, never the first
   wire low_speed_internal_osc_tick = low_speed_internal_osc_s_r[1] & ~low_speed_internal_osc_s_r[2];
   wire low_q     = low_s_r[1];
   wire asleep    = slp_s_r[1];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0]  watchdog_control_r;
   reg [7:0]  reset_key_register_r;
   reg [7:0]  brownout_key_register_r;
   reg [3:0]  reset_cause_flags_r;
   reg [17:0] watchdog_counter_r;
   reg [15:0] key_cnt_r;
   reg        key_pend_r;
   reg [15:0] bor_cnt_r;
   reg [2:0]  rst_cnt_r;
   reg        warm_r;

   wire [4:0] watchdog_enable_key = watchdog_control_r[`RSW_WD_KEY_MSB:`RSW_WD_KEY_LSB];
   wire [2:0] timeout_select      = watchdog_control_r[`RSW_WD_SEL_MSB:0];

   wire wd_on   = (watchdog_enable_key == `RSW_WD_KEY_ON);
   wire wd_bad  = !wd_on && (watchdog_enable_key != `RSW_WD_KEY_OFF);
   wire rk_bad  = (reset_key_register_r != `RSW_RST_KEY_A) &&
                  (reset_key_register_r != `RSW_RST_KEY_B);
   wire bk_on   = (brownout_key_register_r == `RSW_BOR_KEY_ON);
   wire bk_bad  = !bk_on && (brownout_key_register_r != `RSW_BOR_KEY_OFF);
   wire any_bad = wd_bad | rk_bad | bk_bad;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire acc   = psel & penable & pready;
   wire wr    = acc & pwrite;
   wire wr_wc = wr & (paddr == `RSW_OFF_WDOG_CTRL);
   wire wr_rk = wr & (paddr == `RSW_OFF_RST_KEY);
   wire wr_cf = wr & (paddr == `RSW_OFF_CAUSE);
   wire wr_bk = wr & (paddr == `RSW_OFF_BOR_KEY);
   wire wr_fl = wr & (paddr == `RSW_OFF_FLASH_CTL1) &&
                (pwdata[7:0] == `RSW_FLASH_RST_VAL);
   wire known = (paddr == `RSW_OFF_WDOG_CTRL) | (paddr == `RSW_OFF_RST_KEY) |
                (paddr == `RSW_OFF_CAUSE) | (paddr == `RSW_OFF_BOR_KEY) |
                (paddr == `RSW_OFF_FLASH_CTL1) | (paddr == `RSW_OFF_STATUS);

   // ----------------------------------------
   // Watchdog timeout
   // ----------------------------------------
   // divide ratio per select code
   reg [4:0] tap;
   always @*
   begin
      case (timeout_select)
         3'h0:    tap = 5'd7;
         3'h1:    tap = 5'd9;
         3'h2:    tap = 5'd11;
         3'h3:    tap = 5'd13;
         3'h4:    tap = 5'd14;
         3'h5:    tap = 5'd15;
         3'h6:    tap = 5'd16;
         default: tap = 5'd17;
      endcase
   end
   wire [18:0] cnt_inc = {1'b0, watchdog_counter_r} + 19'h1;
   wire wd_ovf  = low_speed_internal_osc_tick && wd_on && cnt_inc[tap + 5'd1];

   wire bor_act = low_q && bk_on && !asleep;
   wire bor_hit = bor_act && (bor_cnt_r == BOR_QUAL_CYC[15:0] - 16'h1);
   wire key_hit = key_pend_r && (key_cnt_r == KEY_DELAY_CYC[15:0] - 16'h1);
   wire cold    = key_hit | bor_hit | wr_fl;
   wire wd_warm = wd_ovf && !asleep;

   // Last count of a reset pulse, cut to the counter width
   localparam integer PULSE_LAST = `RSW_RST_PULSE_CYC - 1;

   // ----------------------------------------
   // APB response
   // ----------------------------------------
   // Access phase is always one cycle: pready follows setup
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= psel & !penable;
         pslverr <= psel & !penable & !known;
         // Writes show zero, so a refused write never carries stale data
         if (psel && !penable && pwrite)
            prdata <= 32'h0;
         else if (psel && !penable)
         begin
            case (paddr)
               `RSW_OFF_WDOG_CTRL: prdata <= {24'h0, watchdog_control_r};
               `RSW_OFF_RST_KEY:   prdata <= {24'h0, reset_key_register_r};
               `RSW_OFF_CAUSE:     prdata <= {28'h0, reset_cause_flags_r};
               `RSW_OFF_BOR_KEY:   prdata <= {24'h0, brownout_key_register_r};
               `RSW_OFF_STATUS:    prdata <= {30'h0, key_pend_r, watchdog_expired_flag};
               default:            prdata <= 32'h0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Key registers
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_control_r      <= `RSW_WDOG_CTRL_POR;
         reset_key_register_r    <= `RSW_RST_KEY_POR;
         brownout_key_register_r <= `RSW_BOR_KEY_POR;
      end
      else
      begin
         if (wr_wc)
            watchdog_control_r <= pwdata[7:0];
         if (wr_rk)
            reset_key_register_r <= pwdata[7:0];
         if (wr_bk)
            brownout_key_register_r <= pwdata[7:0];
         // cold resets restore reset and watchdog keys, warm keeps them
         if (cold)
         begin
            reset_key_register_r <= `RSW_RST_KEY_POR;
            watchdog_control_r   <= `RSW_WDOG_CTRL_POR;
         end
         // key error restores brownout key; brownout keeps it
         if (key_hit || wr_fl)
            brownout_key_register_r <= `RSW_BOR_KEY_POR;
      end
   end

   // ----------------------------------------
   // Watchdog counter
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         watchdog_counter_r <= 18'h0;
      // counter clears on bad key, clear, halt
      else if (cold || wd_bad || watchdog_clear_instruction || halt_instruction ||
               wd_ovf || !wd_on)
         watchdog_counter_r <= 18'h0;
      else if (low_speed_internal_osc_tick)
         watchdog_counter_r <= cnt_inc[17:0];
   end

   // ----------------------------------------
   // Expired flag
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         watchdog_expired_flag <= 1'b0;
      // expired flag, cleared by clear or halt
      else if (wd_ovf)
         watchdog_expired_flag <= 1'b1;
      else if (watchdog_clear_instruction || halt_instruction)
         watchdog_expired_flag <= 1'b0;
   end

   // ----------------------------------------
   // Key-error delay
   // ----------------------------------------
   // Restoring a good key before the count ends cancels the reset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         key_pend_r <= 1'b0;
         key_cnt_r  <= 16'h0;
      end
      // one pending key-error request, counted out
      else if (key_hit || !any_bad)
      begin
         key_pend_r <= 1'b0;
         key_cnt_r  <= 16'h0;
      end
      else
      begin
         key_pend_r <= 1'b1;
         if (key_pend_r)
            key_cnt_r <= key_cnt_r + 16'h1;
      end
   end

   // ----------------------------------------
   // Brownout qualify counter
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bor_cnt_r <= 16'h0;
      else if (bor_act && !bor_hit)
         bor_cnt_r <= bor_cnt_r + 16'h1;
      else
         bor_cnt_r <= 16'h0;
   end

   // ----------------------------------------
   // Reset cause flags
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reset_cause_flags_r <= 4'h0;
      else
      begin
         // set wins over software write of zero
         if (wr_cf)
            reset_cause_flags_r <= reset_cause_flags_r & pwdata[3:0];
         if (key_hit && wd_bad)
            reset_cause_flags_r[`RSW_CAUSE_WDKEY] <= 1'b1;
         if (key_hit && bk_bad)
            reset_cause_flags_r[`RSW_CAUSE_BORKEY] <= 1'b1;
         if (key_hit && rk_bad)
            reset_cause_flags_r[`RSW_CAUSE_SOFTKEY] <= 1'b1;
         if (bor_hit)
            reset_cause_flags_r[`RSW_CAUSE_BOR] <= 1'b1;
      end
   end

   // ----------------------------------------
   // Reset pulse sequencer
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_cnt_r <= 3'h7;
         warm_r    <= 1'b0;
      end
      else if (cold || wd_warm)
      begin
         rst_cnt_r <= PULSE_LAST[2:0];
         warm_r    <= wd_warm & !cold;
      end
      else if (rst_cnt_r != 3'h0)
         rst_cnt_r <= rst_cnt_r - 3'h1;
   end

   // ----------------------------------------
   // Reset outputs
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // power-on reset pulse drives ports to inputs
         sys_reset   <= 1'b1;
         port_init   <= 1'b1;
         pc_sp_clear <= 1'b1;
      end
      else
      begin
         sys_reset   <= cold | wd_warm | (rst_cnt_r > 3'h1);
         port_init   <= cold | wd_warm | ((rst_cnt_r > 3'h1) & !warm_r);
         pc_sp_clear <= cold | wd_ovf | (rst_cnt_r > 3'h1);
      end
   end

endmodule

// ### core/rsw_consts.vh
/*
 Constants for the reset-source and watchdog controller: register
 offsets, key values, field positions, reset values and timing counts.
 Assumes inclusion by bare name from core design files.
*/
`ifndef RSW_CONSTS_VH
`define RSW_CONSTS_VH

// ----------------------------------------
// Register offsets (APB byte addresses)
// ----------------------------------------
`define RSW_OFF_WDOG_CTRL   12'h000
`define RSW_OFF_RST_KEY     12'h004
`define RSW_OFF_CAUSE       12'h008
`define RSW_OFF_BOR_KEY     12'h00c
`define RSW_OFF_FLASH_CTL1  12'h010
`define RSW_OFF_STATUS      12'h014

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSW_WDOG_CTRL_POR   8'h53
`define RSW_RST_KEY_POR     8'h55
`define RSW_BOR_KEY_POR     8'h5a

// ----------------------------------------
// Key values
// ----------------------------------------
`define RSW_WD_KEY_OFF      5'h15
`define RSW_WD_KEY_ON       5'h0a
`define RSW_RST_KEY_A       8'h55
`define RSW_RST_KEY_B       8'haa
`define RSW_BOR_KEY_ON      8'h5a
`define RSW_BOR_KEY_OFF     8'ha5
`define RSW_FLASH_RST_VAL   8'h55

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSW_WD_KEY_MSB      7
`define RSW_WD_KEY_LSB      3
`define RSW_WD_SEL_MSB      2
`define RSW_CAUSE_WDKEY     0
`define RSW_CAUSE_BORKEY    1
`define RSW_CAUSE_BOR       2
`define RSW_CAUSE_SOFTKEY   3

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSW_KEY_DELAY_CYC   16
`define RSW_BOR_QUAL_CYC    10
`define RSW_RST_PULSE_CYC   4

`endif

// ### tb/rsw_ctrl_assertions.sv
/*
 Port checker for rsw_ctrl, bound to every instance at the foot.
 Assumes one pclk domain and an APB master that waits for pready.
*/
`timescale 1ns/1ps
module rsw_ctrl_assertions
#(parameter KEY_DELAY_CYC = 16, parameter BOR_QUAL_CYC = 10)
(
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        low_supply,
   input wire        watchdog_clear_instruction,
   input wire        sys_reset,
   input wire        watchdog_expired_flag
);
   // ----------
   // Properties
   // ----------
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire       wr = psel && penable && pready && pwrite;
   wire [7:0] d  = pwdata[7:0];
   wire       rk_bad = wr && paddr == 12'h004 && d != 8'h55 && d != 8'haa;
   wire       wk_bad = wr && paddr == 12'h000 && d[7:3] != 5'h15 && d[7:3] != 5'h0a;
   wire       bk_bad = wr && paddr == 12'h00c && d != 8'h5a && d != 8'ha5;
   AST_APB_ONE: assert property (psel && !penable |=> pready)
      else $error("access phase not answered");
   AST_SLVERR: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refused access carried data");
   AST_RK_DLY: assert property (rk_bad |=> (!sys_reset) [*8])
      else $error("reset key error fired early");
   AST_WK_DLY: assert property (wk_bad |=> (!sys_reset) [*8])
      else $error("watchdog key error fired early");
   AST_BK_DLY: assert property (bk_bad |=> (!sys_reset) [*8])
      else $error("brownout key error fired early");
   AST_FLASH: assert property (wr && paddr == 12'h010 && d == 8'h55 |-> ##[1:30] sys_reset)
      else $error("flash control write gave no reset");
   AST_BOR_QUAL: assert property ($rose(low_supply) |=> (!sys_reset) [*8])
      else $error("brownout not qualified");
   AST_EXP_CLR: assert property (watchdog_clear_instruction |-> ##[1:3] !watchdog_expired_flag)
      else $error("expired flag not cleared");
endmodule

bind rsw_ctrl rsw_ctrl_assertions
   #(.KEY_DELAY_CYC(KEY_DELAY_CYC), .BOR_QUAL_CYC(BOR_QUAL_CYC))
   u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
          .pready, .pslverr, .low_supply, .watchdog_clear_instruction,
          .sys_reset, .watchdog_expired_flag);

// ### tb/rsw_core_model.sv
/*
 Core model: one-cycle watchdog clear and halt instruction pulses.
 Assumes the bench calls pulse from its main sequence.
*/
`timescale 1ns/1ps
module rsw_core_model
(
   input  wire pclk,
   output reg  watchdog_clear_instruction,
   output reg  halt_instruction
);
   // -----------
   // Instruction
   // -----------
   initial
   begin
      watchdog_clear_instruction = 1'b0;
      halt_instruction = 1'b0;
   end
   task pulse(input h);
   begin
      @(posedge pclk);
      if (h)
         halt_instruction <= 1'b1;
      else
         watchdog_clear_instruction <= 1'b1;
      @(posedge pclk);
      halt_instruction <= 1'b0;
      watchdog_clear_instruction <= 1'b0;
   end
   endtask
endmodule

// ### tb/test_rsw_ctrl.sv
/*
 Self-checking bench for rsw_ctrl: APB tasks and reset-source tests.
 Assumes the core model for instructions; slow clock is pclk/4.
*/
`timescale 1ns/1ps
module test_rsw_ctrl;
   reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0, q;
   reg         low_speed_internal_osc_clk = 1'b0, low_supply = 1'b0, sleep_mode = 1'b0, serr;
   reg  [1:0]  div = 2'h0, snap;
   wire [31:0] prdata;
   wire        pready, pslverr, watchdog_clear_instruction, halt_instruction;
   wire        sys_reset, pc_sp_clear, watchdog_expired_flag, port_init;
   integer     fails = 0, n_tests = 0;
   // -----
   // Bench
   // -----
   always #5 pclk = ~pclk;
   // Slow tick every 4 cycles keeps 2^8 timeouts short
   always @(posedge pclk)
   begin
      div <= div + 2'h1;
      low_speed_internal_osc_clk <= div[1];
   end
   rsw_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .low_speed_internal_osc_clk, .low_supply, .sleep_mode, .watchdog_clear_instruction,
      .halt_instruction, .sys_reset, .pc_sp_clear, .watchdog_expired_flag, .port_init);
   rsw_core_model i_core (.pclk, .watchdog_clear_instruction, .halt_instruction);
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task give_verdict;
   begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   // Request held until the edge that samples pready
   task apb(input w, input [11:0] a, input [31:0] dat);
      integer n;
   begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n = n + 1;
      end
      chk(n < 20, 1);
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task rd(input [11:0] a, input [31:0] e);
   begin
      apb(1'b0, a, 32'h0);
      chk(q, e);
   end
   endtask
   // Waits for a reset pulse; e says whether one must come in [lo, hi)
   task rst_in(input s, input integer lo, input integer hi, input e);
      integer n;
   begin
      n = 0;
      #1;
      while ((s ? pc_sp_clear : sys_reset) !== 1'b1 && n < hi)
      begin
         @(posedge pclk);
         #1;
         n = n + 1;
      end
      snap = s ? {sys_reset, port_init} : {pc_sp_clear, port_init};
      chk(n >= lo && n < hi, e);
      @(posedge pclk);
      low_supply <= 1'b0;
      while (sys_reset !== 1'b0 || pc_sp_clear !== 1'b0) @(posedge pclk);
      repeat (6) @(posedge pclk);
   end
   endtask
   task key_err(input [11:0] a, input [31:0] v, input integer lo, input [31:0] m,
                input [31:0] p);
   begin
      apb(1'b1, a, v);
      rst_in(1'b0, lo, 30, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk(q & 32'hb, m);
      apb(1'b1, 12'h008, 32'h0);
      rd(12'h008, 32'h0);
      rd(a, p);
   end
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      fails = fails + 1;
      give_verdict;
   end
   // -----
   // Tests
   // -----
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(12'h000, 32'h53);
      rd(12'h004, 32'h55);
      rd(12'h00c, 32'h5a);
      rd(12'h020, 32'h0);
      chk(serr, 1'b1);
      apb(1'b1, 12'h004, 32'haa);
      rd(12'h004, 32'haa);
      rst_in(1'b0, 0, 40, 1'b0);
      key_err(12'h004, 32'h12, 15, 32'h8, 32'h55);
      key_err(12'h000, 32'h03, 15, 32'h1, 32'h53);
      key_err(12'h00c, 32'h11, 15, 32'h2, 32'h5a);
      key_err(12'h010, 32'h55, 0, 32'h0, 32'h0);
      apb(1'b1, 12'h008, 32'hf);
      rd(12'h008, 32'h0);
      low_supply <= 1'b1;
      repeat (5) @(posedge pclk);
      low_supply <= 1'b0;
      rst_in(1'b0, 0, 30, 1'b0);
      low_supply <= 1'b1;
      rst_in(1'b0, 10, 40, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk(q & 32'hf, 32'h4);
      apb(1'b1, 12'h008, 32'h0);
      rd(12'h00c, 32'h5a);
      apb(1'b1, 12'h00c, 32'ha5);
      low_supply <= 1'b1;
      rst_in(1'b0, 0, 40, 1'b0);
      apb(1'b1, 12'h00c, 32'h5a);
      sleep_mode <= 1'b1;
      low_supply <= 1'b1;
      rst_in(1'b0, 0, 40, 1'b0);
      sleep_mode <= 1'b0;
      apb(1'b1, 12'h000, 32'ha8);
      rst_in(1'b0, 0, 1200, 1'b0);
      i_core.pulse(1'b0);
      apb(1'b1, 12'h004, 32'haa);
      apb(1'b1, 12'h000, 32'h50);
      repeat (600) @(posedge pclk);
      i_core.pulse(1'b0);
      rst_in(1'b0, 1000, 1060, 1'b1);
      chk({snap, watchdog_expired_flag}, 3'h7);
      rd(12'h004, 32'haa);
      i_core.pulse(1'b0);
      repeat (2) @(posedge pclk);
      chk(watchdog_expired_flag, 1'b0);
      apb(1'b1, 12'h000, 32'h50);
      sleep_mode <= 1'b1;
      i_core.pulse(1'b1);
      rst_in(1'b1, 1000, 1060, 1'b1);
      chk({snap, watchdog_expired_flag}, 3'h1);
      sleep_mode <= 1'b0;
      give_verdict;
   end
endmodule
